// ---- rtl/wit_cnt_if.sv ----
`timescale 1ns/1ns
interface wit_cnt_if;
  import wit_pkg::*;
  logic tick;
  logic run;
  logic clear;
  logic [WIT_RATE_W-1:0] rate;
  logic expire;
  logic [WIT_CNT_W-1:0] count;
  modport ctl (output tick, output run, output clear, output rate, input expire, input count);
  modport cnt (input tick, input run, input clear, input rate, output expire, output count);
endinterface : wit_cnt_if

// ---- rtl/wit_counter.sv ----
`timescale 1ns/1ns
module wit_counter import wit_pkg::*; (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  wit_cnt_if.cnt bus
);
  logic [WIT_CNT_W-1:0] count;
  logic expire;
  wire logic at_end = (count >= wit_limit(bus.rate)); // Also ends a count left above a lowered rate
  wire logic step = bus.run && bus.tick;

  // Clear dominates so a feed always restarts from zero
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || bus.clear) begin
      count <= '0; // RULE_17
      expire <= 1'b0;
    end else begin
      expire <= step && at_end; // RULE_04
      if (step) begin
        count <= at_end ? '0 : count + 21'h000001;
      end
    end
  end

  assign bus.count = count;
  assign bus.expire = expire;
endmodule : wit_counter

// ---- rtl/wit_pkg.sv ----
package wit_pkg;
  // Register port geometry
  localparam int WIT_AW = 4;
  localparam int WIT_DW = 8;
  localparam logic [3:0] WIT_ADDR_CTRL = 4'h0;
  localparam logic [3:0] WIT_ADDR_FEED = 4'h1;
  localparam logic [3:0] WIT_ADDR_STAT = 4'h2;
  localparam logic [3:0] WIT_ADDR_MASK = 4'h3;
  localparam logic [3:0] WIT_ADDR_CNT = 4'h4;

  // Control register fields
  localparam int WIT_CTRL_OVF = 5;
  localparam int WIT_CTRL_RUN = 4;
  localparam int WIT_CTRL_CLK = 3;
  localparam int WIT_RATE_W = 3;
  localparam logic [7:0] WIT_CTRL_RST = 8'h00;

  // Status and mask fields
  localparam int WIT_ST_W = 2;
  localparam int WIT_ST_OVF = 0;
  localparam int WIT_ST_BADFEED = 1;
  localparam logic [1:0] WIT_ST_RST = 2'h0;

  // Feed sequence values
  localparam logic [7:0] WIT_FEED_FIRST = 8'h1E;
  localparam logic [7:0] WIT_FEED_SECOND = 8'hE1;

  // Timeout clocks are 8192 doubled per rate step
  localparam int WIT_CNT_W = 21;
  localparam logic [20:0] WIT_TIMEOUT_BASE = 21'h002000;
  localparam int WIT_CPU_DIV = 6;

  // Internal reset pulse length
  localparam int WIT_CLK_PERIOD_NS = 10;
  localparam int WIT_RST_TIME_NS = 1000;
  localparam int WIT_RST_CYCLES = (WIT_RST_TIME_NS + WIT_CLK_PERIOD_NS - 1) / WIT_CLK_PERIOD_NS;
  localparam int WIT_RST_CNT_W = 7;

  typedef enum logic [1:0] {
    WIT_IDLE,
    WIT_RST_PULSE,
    WIT_OSC_WAIT
  } wit_state_t;

  // Terminal count for a rate select
  function automatic logic [20:0] wit_limit(input logic [2:0] rate);
    wit_limit = (WIT_TIMEOUT_BASE << rate) - 21'h000001;
  endfunction : wit_limit
endpackage : wit_pkg

// ---- rtl/wit_top.sv ----
// Function
// RULE_01 - Watchdog mode counts only ticks of the independent RC oscillator.
// RULE_02 - Watchdog mode must be fed; timeout resets CPU; cannot be stopped.
// RULE_03 - Without watchdog mode the timer is an interval timer raising interrupts.
// RULE_04 - Three-bit rate select picks one of eight timeout lengths.
// RULE_05 - In watchdog mode the control register accepts only one write.
// RULE_06 - Software should feed first, then set the rate, within 10 ms.
// RULE_07 - Feed is write 1Eh then E1h to the feed register.
// RULE_08 - Other accesses may fall between the two feed writes.
// RULE_09 - Wrong feed sequence changes nothing; timeout stays as scheduled. Code sets status bit WIT_ST_BADFEED.
// RULE_10 - CPU oscillator failure does not stop the watchdog count.
// RULE_11 - Other chip reset sources hold the timer inactive meanwhile.
// RULE_12 - Timeout drives internal reset for about one microsecond.
// RULE_13 - Timeout in power down restarts oscillator; resume after it is stable.
// RULE_14 - Overflow flag sets on timeout, clears on valid feed.
// RULE_15 - Run bit starts and stops timer; forced to 1 in watchdog mode.
// RULE_16 - Clock select picks CPU clock/6 or RC; forced to RC in watchdog mode.
// RULE_17 - Valid feed restarts count from zero for a full period.
`timescale 1ns/1ns
module wit_top import wit_pkg::*; #(
  parameter int RST_CYCLES = WIT_RST_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [WIT_AW-1:0] i_addr,
  input wire logic [WIT_DW-1:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_rc_osc,
  input wire logic i_watchdog_enable_config,
  input wire logic i_chip_rst_other,
  input wire logic i_power_down,
  input wire logic i_osc_stable,
  output logic [WIT_DW-1:0] o_rd_data,
  output logic o_irq,
  output logic o_wdt_rst,
  output logic o_osc_restart,
  output logic o_exec_hold
);
  // Pin synchronisers: stage one feeds only stage two
  logic [3:0] sync1;
  logic [3:0] sync2;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
    end else begin
      sync1 <= {i_osc_stable, i_chip_rst_other, i_watchdog_enable_config, i_rc_osc};
      sync2 <= sync1;
    end
  end

  wire logic rc_s = sync2[0];
  wire logic watchdog_enable_config = sync2[1];
  wire logic rst_other_s = sync2[2];
  wire logic osc_stable_s = sync2[3];

  // RC oscillator edge detect from the synchronised level
  logic rc_prev;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rc_prev <= 1'b0;
    end else begin
      rc_prev <= rc_s;
    end
  end
  wire logic rc_tick = rc_s && !rc_prev;

  // CPU clock divided by 6
  logic [2:0] div_cnt;
  wire logic div_end = (div_cnt == 3'(WIT_CPU_DIV - 1));
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || div_end) begin
      div_cnt <= 3'h0;
    end else begin
      div_cnt <= div_cnt + 3'h1;
    end
  end

  // Register, feed arm and reset sequencer state
  logic ovf;
  logic run_bit;
  logic clk_bit;
  logic [WIT_RATE_W-1:0] rate;
  logic ctrl_locked;
  logic feed_armed;
  logic [WIT_ST_W-1:0] status;
  logic [WIT_ST_W-1:0] mask;
  wit_state_t state;
  logic [WIT_RST_CNT_W-1:0] pulse_cnt;
  logic pd_seen;

  // Effective mode bits after config forcing
  wire logic run_eff = watchdog_enable_config || run_bit; // RULE_15
  wire logic clk_eff = !watchdog_enable_config && clk_bit; // RULE_16
  wire logic tick_sel = clk_eff ? div_end : rc_tick; // RULE_01 RULE_10

  // Register decode
  wire logic wr_ctrl = i_wr && (i_addr == WIT_ADDR_CTRL);
  wire logic wr_feed = i_wr && (i_addr == WIT_ADDR_FEED);
  wire logic wr_stat = i_wr && (i_addr == WIT_ADDR_STAT);
  wire logic wr_mask = i_wr && (i_addr == WIT_ADDR_MASK);
  wire logic ctrl_ok = wr_ctrl && !(watchdog_enable_config && ctrl_locked); // RULE_05

  // Feed sequence decode; unrelated accesses leave the arm alone
  wire logic feed_first = wr_feed && (i_wr_data == WIT_FEED_FIRST); // RULE_07
  wire logic feed_ok = wr_feed && feed_armed && (i_wr_data == WIT_FEED_SECOND); // RULE_07 RULE_08
  wire logic feed_bad = wr_feed && !feed_first && !feed_ok; // RULE_09

  // Counter hookup
  wit_cnt_if cnt_bus ();
  wire logic hold_other = rst_other_s; // RULE_11
  wire logic in_reset = (state != WIT_IDLE);
  assign cnt_bus.tick = tick_sel;
  assign cnt_bus.run = run_eff;
  assign cnt_bus.clear = feed_ok || hold_other || in_reset; // RULE_17
  assign cnt_bus.rate = rate;

  wit_counter wit_counter_inst (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .bus(cnt_bus)
  );

  wire logic expire = cnt_bus.expire;
  wire logic wd_timeout = expire && watchdog_enable_config; // RULE_02
  wire logic iv_timeout = expire && !watchdog_enable_config; // RULE_03

  // Feed arm: first value arms, anything else on the feed register disarms
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || in_reset) begin
      feed_armed <= 1'b0;
    end else if (wr_feed) begin
      feed_armed <= feed_first; // RULE_07
    end
  end

  // Overflow flag: a set in the same cycle as a feed wins
  wire logic next_ovf = expire ? 1'b1 : (feed_ok ? 1'b0 : ovf); // RULE_14

  // Control fields; a watchdog reset returns them to the power-up rate
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ovf <= WIT_CTRL_RST[WIT_CTRL_OVF];
      run_bit <= WIT_CTRL_RST[WIT_CTRL_RUN];
      clk_bit <= WIT_CTRL_RST[WIT_CTRL_CLK];
      rate <= WIT_CTRL_RST[WIT_RATE_W-1:0];
    end else begin
      ovf <= next_ovf;
      if (wd_timeout) begin
        run_bit <= 1'b1;
        clk_bit <= 1'b0;
        rate <= WIT_CTRL_RST[WIT_RATE_W-1:0];
      end else if (ctrl_ok) begin
        run_bit <= i_wr_data[WIT_CTRL_RUN]; // RULE_15
        clk_bit <= i_wr_data[WIT_CTRL_CLK]; // RULE_16
        rate <= i_wr_data[WIT_RATE_W-1:0]; // RULE_04
      end
    end
  end

  // Write-once lock reopens after any chip reset
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || wd_timeout || hold_other) begin
      ctrl_locked <= 1'b0;
    end else if (wr_ctrl && watchdog_enable_config) begin
      ctrl_locked <= 1'b1; // RULE_05
    end
  end

  // Sticky event bits, write one to clear, set wins
  wire logic [WIT_ST_W-1:0] st_set = {feed_bad, iv_timeout}; // RULE_03
  wire logic [WIT_ST_W-1:0] st_clr = wr_stat ? i_wr_data[WIT_ST_W-1:0] : '0;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      status <= WIT_ST_RST;
      mask <= WIT_ST_RST;
    end else begin
      status <= (status & ~st_clr) | st_set;
      if (wr_mask) begin
        mask <= i_wr_data[WIT_ST_W-1:0];
      end
    end
  end

  // Interrupt level from flop
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(status & mask);
    end
  end

  // Reset sequencer: pulse, then optional oscillator wait
  wit_state_t next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      WIT_IDLE: begin
        if (wd_timeout) begin
          next_state = WIT_RST_PULSE;
        end
      end
      WIT_RST_PULSE: begin
        if (pulse_cnt == WIT_RST_CNT_W'(RST_CYCLES - 1)) begin
          next_state = pd_seen ? WIT_OSC_WAIT : WIT_IDLE; // RULE_13
        end
      end
      WIT_OSC_WAIT: begin
        if (osc_stable_s) begin
          next_state = WIT_IDLE; // RULE_13
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state <= WIT_IDLE;
      pulse_cnt <= '0;
    end else begin
      state <= next_state;
      pulse_cnt <= (state == WIT_RST_PULSE) ? pulse_cnt + WIT_RST_CNT_W'(1) : '0; // RULE_12
    end
  end

  // Power down is sampled at the timeout so a later wake cannot skip the wait
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pd_seen <= 1'b0;
    end else if (wd_timeout) begin
      pd_seen <= i_power_down;
    end else if (next_state == WIT_IDLE) begin
      pd_seen <= 1'b0;
    end
  end

  // Reset outputs straight from flops
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_wdt_rst <= 1'b0;
      o_osc_restart <= 1'b0;
      o_exec_hold <= 1'b0;
    end else begin
      o_wdt_rst <= (next_state == WIT_RST_PULSE); // RULE_12 RULE_02
      o_osc_restart <= (next_state != WIT_IDLE) && (wd_timeout ? i_power_down : pd_seen); // RULE_13
      o_exec_hold <= (next_state != WIT_IDLE); // RULE_13
    end
  end

  // Read mux; feed register and unmapped addresses read zero
  wire logic [WIT_DW-1:0] ctrl_rd = {2'b00, ovf, run_eff, clk_eff, rate};
  wire logic [WIT_DW-1:0] cnt_rd = cnt_bus.count[WIT_CNT_W-1 -: WIT_DW];
  logic [WIT_DW-1:0] rd_mux;
  always_comb begin
    unique case (i_addr)
      WIT_ADDR_CTRL: rd_mux = ctrl_rd;
      WIT_ADDR_STAT: rd_mux = {6'h00, status};
      WIT_ADDR_MASK: rd_mux = {6'h00, mask};
      WIT_ADDR_CNT: rd_mux = cnt_rd;
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rd_data <= 8'h00;
    end else begin
      o_rd_data <= i_rd ? rd_mux : 8'h00;
    end
  end
endmodule : wit_top

// ---- tb/wit_props.sv ----
`timescale 1ns/1ns
module wit_props import wit_pkg::*; #(
  parameter int RST_CYCLES = WIT_RST_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [WIT_AW-1:0] i_addr,
  input wire logic i_rd,
  input wire logic i_watchdog_enable_config,
  input wire logic i_chip_rst_other,
  input wire logic i_power_down,
  input wire logic i_osc_stable,
  input wire logic [WIT_DW-1:0] o_rd_data,
  input wire logic o_wdt_rst,
  input wire logic o_osc_restart,
  input wire logic o_exec_hold
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  logic [7:0] hi_cnt;
  logic rd_ctl;
  // Pulse length so far; a repetition would need the full count unrolled
  always_ff @(posedge i_clk) begin
    hi_cnt <= (i_sys_rst || !o_wdt_rst) ? 8'h00 : hi_cnt + 8'h01;
  end
  // Control read with the config settled through its synchroniser
  assign rd_ctl = i_rd && i_addr == WIT_ADDR_CTRL && i_watchdog_enable_config;
  property p_rst_len; $fell(o_wdt_rst) |-> hi_cnt == 8'(RST_CYCLES); endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset pulse length wrong");
  property p_hold; o_wdt_rst |-> o_exec_hold; endproperty
  a_hold: assert property (p_hold) else $error("hold low in pulse");
  property p_osc_hold; o_osc_restart |-> o_exec_hold; endproperty
  a_osc_hold: assert property (p_osc_hold) else $error("restart without hold");
  property p_pd; $rose(o_wdt_rst) |-> o_osc_restart == $past(i_power_down); endproperty
  a_pd: assert property (p_pd) else $error("restart level wrong");
  property p_wait; o_osc_restart && !o_wdt_rst && !i_osc_stable |=> o_exec_hold; endproperty
  a_wait: assert property (p_wait) else $error("resumed early");
  property p_intv; $rose(o_wdt_rst) |-> $past(i_watchdog_enable_config, 3); endproperty
  a_intv: assert property (p_intv) else $error("reset in interval mode");
  property p_run; rd_ctl && $past(i_watchdog_enable_config, 3) |=> o_rd_data[WIT_CTRL_RUN]; endproperty
  a_run: assert property (p_run) else $error("run not forced");
  property p_clk; rd_ctl && $past(i_watchdog_enable_config, 3) |=> !o_rd_data[WIT_CTRL_CLK]; endproperty
  a_clk: assert property (p_clk) else $error("clock select not forced");
  property p_other; i_chip_rst_other [*6] |=> !$rose(o_wdt_rst); endproperty
  a_other: assert property (p_other) else $error("timeout in other reset");
endmodule : wit_props

// ---- tb/wit_top_tb.sv ----
`timescale 1ns/1ns
module wit_top_tb import wit_pkg::*;;
  localparam int RC = 20;
  logic i_clk, i_sys_rst, i_wr, i_rd, i_watchdog_enable_config, i_chip_rst_other;
  logic i_rc_osc = 1'b0;
  logic i_power_down, i_osc_stable, o_irq, o_wdt_rst, o_osc_restart, o_exec_hold;
  logic [WIT_AW-1:0] i_addr;
  logic [WIT_DW-1:0] i_wr_data, o_rd_data;
  int failures, check_count, t0, n;
  int cyc = 0;
  wit_top #(.RST_CYCLES(RC)) wit_top_inst (.i_clk, .i_sys_rst, .i_addr, .i_wr_data, .i_wr, .i_rd,
    .i_rc_osc, .i_watchdog_enable_config, .i_chip_rst_other, .i_power_down, .i_osc_stable,
    .o_rd_data, .o_irq, .o_wdt_rst, .o_osc_restart, .o_exec_hold);
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // Fast oscillator stand-in keeps the 8192-tick timeout short
  always @(posedge i_clk) begin
    i_rc_osc <= ~i_rc_osc;
    cyc <= cyc + 1;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wr_data <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    check(o_rd_data, e);
  endtask : rdc
  task automatic wait_rst(input logic lvl);
    n = 0;
    while (o_wdt_rst !== lvl && n < 20000) begin
      @(negedge i_clk);
      n++;
    end
  endtask : wait_rst
  task automatic reset_dut(input logic wd);
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    i_watchdog_enable_config <= wd;
    repeat (16) @(posedge i_clk);
    i_sys_rst <= 1'b0;
  endtask : reset_dut
  task automatic t_irq;
    rdc(WIT_ADDR_CTRL, 8'h00);
    rdc(4'hF, 8'h00);
    wr(WIT_ADDR_FEED, 8'h55);
    rdc(WIT_ADDR_STAT, 8'h02);
    check(o_irq, 1'b0);
    check(o_wdt_rst, 1'b0);
    wr(WIT_ADDR_MASK, 8'h02);
    rdc(WIT_ADDR_MASK, 8'h02);
    check(o_irq, 1'b1);
    wr(WIT_ADDR_STAT, 8'h02);
    rdc(WIT_ADDR_STAT, 8'h00);
    check(o_irq, 1'b0);
    $display("t_irq done");
  endtask : t_irq
  task automatic t_interval;
    wr(WIT_ADDR_MASK, 8'h01);
    wr(WIT_ADDR_CTRL, 8'h10);
    t0 = cyc;
    while (o_irq !== 1'b1 && cyc - t0 < 20000)
      @(negedge i_clk);
    check(cyc - t0 >= 16370 && cyc - t0 <= 16410, 1'b1);
    check(o_wdt_rst, 1'b0);
    rdc(WIT_ADDR_CTRL, 8'h30);
    wr(WIT_ADDR_CTRL, 8'h00);
    wr(WIT_ADDR_STAT, 8'h01);
    repeat (17000) @(posedge i_clk);
    rdc(WIT_ADDR_STAT, 8'h00);
    wr(WIT_ADDR_FEED, 8'h1E);
    wr(WIT_ADDR_FEED, 8'hE1);
    rdc(WIT_ADDR_CTRL, 8'h00);
    $display("t_interval done");
  endtask : t_interval
  task automatic t_wd;
    reset_dut(1'b1);
    i_chip_rst_other <= 1'b1;
    repeat (10) @(posedge i_clk);
    i_chip_rst_other <= 1'b0;
    // Let the released pin clear its synchroniser before software runs
    repeat (3) @(posedge i_clk);
    wr(WIT_ADDR_FEED, 8'h1E);
    wr(WIT_ADDR_FEED, 8'hE1);
    wr(WIT_ADDR_CTRL, 8'h08);
    wr(WIT_ADDR_CTRL, 8'h0B);
    rdc(WIT_ADDR_CTRL, 8'h10);
    repeat (8000) @(posedge i_clk);
    wr(WIT_ADDR_FEED, 8'h1E);
    rdc(WIT_ADDR_STAT, 8'h00);
    wr(WIT_ADDR_FEED, 8'hE1);
    t0 = cyc;
    repeat (4000) @(posedge i_clk);
    wr(WIT_ADDR_FEED, 8'h1E);
    wr(WIT_ADDR_FEED, 8'h55);
    wait_rst(1'b1);
    check(cyc - t0 >= 16370 && cyc - t0 <= 16410, 1'b1);
    check(o_osc_restart, 1'b0);
    wait_rst(1'b0);
    check(n, RC);
    repeat (3) @(negedge i_clk);
    check(o_exec_hold, 1'b0);
    rdc(WIT_ADDR_CTRL, 8'h30);
    @(posedge i_clk);
    i_power_down <= 1'b1;
    i_osc_stable <= 1'b0;
    wait_rst(1'b1);
    check(o_osc_restart, 1'b1);
    wait_rst(1'b0);
    repeat (20) @(negedge i_clk);
    check(o_exec_hold, 1'b1);
    @(posedge i_clk);
    i_osc_stable <= 1'b1;
    repeat (6) @(negedge i_clk);
    check(o_exec_hold, 1'b0);
    $display("t_wd done");
  endtask : t_wd
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report
  initial begin
    i_sys_rst = 1'b1;
    i_addr = 4'h0;
    i_wr_data = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_watchdog_enable_config = 1'b0;
    i_chip_rst_other = 1'b0;
    i_power_down = 1'b0;
    i_osc_stable = 1'b1;
    failures = 0;
    check_count = 0;
    reset_dut(1'b0);
    t_irq;
    t_interval;
    t_wd;
    final_report;
  end
  // Tests need about 75k cycles; cut off at 100k
  initial begin
    #1000000;
    failures++;
    final_report;
  end
endmodule : wit_top_tb
bind wit_top wit_props #(.RST_CYCLES(RST_CYCLES)) wit_props_inst (.i_clk, .i_sys_rst, .i_addr, .i_rd,
  .i_watchdog_enable_config, .i_chip_rst_other, .i_power_down, .i_osc_stable, .o_rd_data, .o_wdt_rst,
  .o_osc_restart, .o_exec_hold);
